//--- src/flash_cycle_table.sv
// Command cycle table: address/data of each write in a sequence
module flash_cycle_table
  import flash_host_pkg::*;
(
  // Clock
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic clk_en,
  // Lookup
  input wire logic [2:0] op,
  input wire logic bypass,
  input wire logic [2:0] idx,
  input wire logic [15:0] user_addr,
  input wire logic [7:0] user_data,
  // Registered result
  output logic [15:0] cyc_addr,
  output logic [7:0] cyc_data,
  output logic cyc_last
);

  // ****************************************************************
  // Registered table state
  // ****************************************************************
  typedef struct packed {
    logic [15:0] a;
    logic [7:0] d;
    logic l;
  } tbl_t;

  tbl_t q_reg; // Registered entry
  tbl_t q_next; // Next entry

  // Table lookup per sequence position
  always_comb begin
    q_next = q_reg;
    q_next.l = 1'b0;
    if (op == op_program && bypass) begin // Two-write program
      q_next.a = (idx == 3'd0) ? unlock_addr_a : user_addr;
      q_next.d = (idx == 3'd0) ? cmd_program : user_data;
      q_next.l = (idx == 3'd1);
    end else begin
      case (idx)
        3'd0: begin
          q_next.a = unlock_addr_a;
          q_next.d = unlock_data_a;
        end
        3'd1: begin
          q_next.a = unlock_addr_b;
          q_next.d = unlock_data_b;
        end
        3'd2: begin
          q_next.a = unlock_addr_a;
          q_next.d = (op == op_program) ? cmd_program : cmd_erase_setup;
        end
        3'd3: begin
          q_next.a = (op == op_program) ? user_addr : unlock_addr_a;
          q_next.d = (op == op_program) ? user_data : unlock_data_a;
          q_next.l = (op == op_program); // Four-write program
        end
        3'd4: begin
          q_next.a = unlock_addr_b;
          q_next.d = unlock_data_b;
        end
        default: begin
          q_next.a = user_addr;
          q_next.d = cmd_sector_erase;
          q_next.l = 1'b1;
        end
      endcase
    end
  end

  // Register the entry
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      q_reg <= '0;
    end else if (clk_en) begin
      q_reg <= q_next;
    end
  end

  assign cyc_addr = q_reg.a;
  assign cyc_data = q_reg.d;
  assign cyc_last = q_reg.l;

endmodule : flash_cycle_table

//--- src/flash_host_ctrl.sv
// Host controller that drives a parallel NOR flash over its pins
module flash_host_ctrl
  import flash_host_pkg::*;
#(
  parameter int unsigned hv_cycles = hv_setup_cyc,
  parameter int unsigned ready_cycles = reset_ready_cyc
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic clk_en,
  // User request port
  input wire logic req_valid,
  input wire logic [2:0] req_op,
  input wire logic [15:0] req_addr,
  input wire logic [7:0] req_data,
  input wire logic bypass_en,
  input wire logic cs_ctrl_wr,
  input wire logic hv_unprotect,
  input wire logic abort_req,
  output logic req_ready,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic op_busy,
  output logic toggle_seen,
  output logic suspend_toggle_seen,
  // Flash pins
  output logic [15:0] flash_addr,
  input wire logic [7:0] flash_dq_in,
  output logic [7:0] flash_dq_out,
  output logic flash_dq_oe,
  output logic chip_sel_n,
  output logic out_gate_n,
  output logic wr_strobe_n,
  output logic reset_n,
  output logic reset_hv_en,
  input wire logic ready_busy_out_n
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    state_t st;
    logic [2:0] op;
    logic [2:0] idx;
    logic [15:0] uaddr;
    logic [7:0] udata;
    logic [15:0] cnt;
    logic [15:0] addr;
    logic [7:0] dout;
    logic oe;
    logic cs_n;
    logic og_n;
    logic we_n;
    logic rst_n;
    logic hv;
    logic rv;
    logic [7:0] rd;
    logic [7:0] prev;
    logic have_prev;
    logic tg;
    logic stg;
    logic [15:0] rcnt;
  } ctl_t;

  ctl_t s_reg; // Registered state
  ctl_t s_next; // Next state
  logic [7:0] dq_s1_reg, dq_s2_reg; // Data input synchroniser
  logic rb_s1_reg, rb_s2_reg; // Ready/busy synchroniser
  logic [15:0] cyc_addr; // Table address
  logic [7:0] cyc_data; // Table data
  logic cyc_last; // Final write of sequence

  // ****************************************************************
  // Command table
  // ****************************************************************
  flash_cycle_table u_table (
    .mclk(mclk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .op(s_reg.op),
    .bypass(bypass_en),
    .idx(s_reg.idx),
    .user_addr(s_reg.uaddr),
    .user_data(s_reg.udata),
    .cyc_addr(cyc_addr),
    .cyc_data(cyc_data),
    .cyc_last(cyc_last)
  );

  // Two flops on pin inputs before any logic sees them
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      dq_s1_reg <= 8'h00;
      dq_s2_reg <= 8'h00;
      rb_s1_reg <= 1'b1;
      rb_s2_reg <= 1'b1;
    end else if (clk_en) begin
      dq_s1_reg <= flash_dq_in;
      dq_s2_reg <= dq_s1_reg;
      rb_s1_reg <= ready_busy_out_n;
      rb_s2_reg <= rb_s1_reg;
    end
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_comb begin
    s_next = s_reg;
    s_next.rv = 1'b0;
    if (s_reg.cnt != 16'h0000) begin
      s_next.cnt = s_reg.cnt - 16'h0001;
    end
    // Abort by pulling reset low; recovery wait
    if (abort_req && s_reg.rst_n) begin
      s_next.rst_n = 1'b0;
      s_next.rcnt = 16'(ready_cycles);
    end else if (s_reg.rcnt != 16'h0000) begin
      s_next.rcnt = s_reg.rcnt - 16'h0001;
      if (s_reg.rcnt == 16'(ready_cycles - 1)) begin
        s_next.rst_n = 1'b1;
      end
    end
    case (s_reg.st)
      st_idle: begin
        if (req_valid && s_reg.rcnt == 16'h0000) begin
          s_next.op = req_op;
          s_next.uaddr = req_addr;
          s_next.udata = req_data;
          s_next.idx = 3'd0;
          // Keep the last status sample only across back-to-back status reads
          s_next.have_prev = s_reg.have_prev && (req_op == op_status);
          if (req_op == op_prot || req_op == op_unprot) begin
            // Protect selects A6 low, unprotect A6 high
            s_next.uaddr[addr_bit_six] = (req_op == op_unprot);
            s_next.uaddr[addr_bit_one] = 1'b1;
            s_next.uaddr[addr_bit_zero] = 1'b0;
          end
          if ((req_op == op_program || req_op == op_erase) && hv_unprotect) begin
            s_next.hv = 1'b1;
            s_next.cnt = 16'(hv_cycles); // High voltage setup
            s_next.st = st_hv_wait;
          end else begin
            s_next.cnt = 16'(rd_wr_gap_cyc); // Read-to-write gap
            s_next.st = st_gap;
          end
        end
      end
      st_hv_wait: begin
        if (s_reg.cnt == 16'h0000) begin
          s_next.cnt = 16'(rd_wr_gap_cyc);
          s_next.st = st_gap;
        end
      end
      st_gap: begin
        // Select-controlled write: strobe drops a cycle ahead of select
        if (cs_ctrl_wr && s_reg.cnt == 16'h0001
            && (s_reg.op == op_program || s_reg.op == op_erase)) begin
          s_next.we_n = 1'b0;
        end
        if (s_reg.cnt == 16'h0000) begin
          if (s_reg.op == op_program || s_reg.op == op_erase) begin
            // Address set while chip select falls
            s_next.addr = cyc_addr;
            s_next.dout = cyc_data;
            s_next.oe = 1'b1;
            // In select mode the strobe is already low here
            s_next.cs_n = 1'b0;
            s_next.we_n = 1'b0;
            s_next.cnt = 16'(pulse_cyc);
            s_next.st = st_wr_low;
          end else begin
            // Status or array read; prot ops use read address only
            s_next.addr = s_reg.uaddr;
            s_next.cs_n = 1'b0;
            s_next.og_n = 1'b0;
            s_next.cnt = 16'(pulse_cyc + 2);
            s_next.st = st_rd_low;
          end
        end
      end
      st_wr_low: begin
        if (s_reg.cnt == 16'h0000) begin
          // Data latched on rising strobe edge
          s_next.we_n = 1'b1;
          s_next.cs_n = 1'b1;
          s_next.cnt = 16'(pulse_high_cyc);
          s_next.st = st_wr_high;
        end
      end
      st_wr_high: begin
        if (s_reg.cnt == 16'h0000) begin
          s_next.oe = 1'b0;
          if (cyc_last) begin
            // Device goes busy within its delay
            s_next.cnt = 16'(busy_delay_cyc + 2);
            s_next.st = st_done;
          end else begin
            s_next.idx = s_reg.idx + 3'd1;
            s_next.st = st_gap;
            s_next.cnt = 16'h0001;
          end
        end
      end
      st_rd_low: begin
        if (s_reg.cnt == 16'h0000) begin
          // End each read with a fresh strobe edge
          s_next.cs_n = 1'b1;
          s_next.og_n = 1'b1;
          s_next.rd = dq_s2_reg;
          s_next.rv = 1'b1;
          if (s_reg.have_prev) begin
            // Busy toggle at any address
            s_next.tg = (dq_s2_reg[busy_toggle_bit] != s_reg.prev[busy_toggle_bit]);
            // Suspend toggle only for suspended sector
            s_next.stg = (dq_s2_reg[erase_suspend_toggle_bit]
                          != s_reg.prev[erase_suspend_toggle_bit]);
          end else begin
            // Nothing to compare against yet, so no stale toggle report
            s_next.tg = 1'b0;
            s_next.stg = 1'b0;
          end
          s_next.prev = dq_s2_reg;
          s_next.have_prev = (s_reg.op == op_status);
          s_next.st = st_done;
          s_next.cnt = 16'(rd_wr_gap_cyc);
        end
      end
      st_done: begin
        if (s_reg.cnt == 16'h0000) begin
          s_next.hv = 1'b0;
          s_next.st = st_idle;
        end
      end
      default: s_next.st = st_idle;
    endcase
  end

  // Register all state
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s_reg <= '{st: st_idle, op: op_read, cs_n: 1'b1, og_n: 1'b1, we_n: 1'b1,
                 rst_n: 1'b1, default: '0};
    end else if (clk_en) begin
      s_reg <= s_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign req_ready = (s_reg.st == st_idle) && (s_reg.rcnt == 16'h0000);
  assign rsp_valid = s_reg.rv;
  assign rsp_data = s_reg.rd;
  // Busy pin plus our own sequencing; device erase ~0.5 s
  assign op_busy = !rb_s2_reg || (s_reg.st != st_idle);
  assign toggle_seen = s_reg.tg;
  assign suspend_toggle_seen = s_reg.stg;
  assign flash_addr = s_reg.addr;
  assign flash_dq_out = s_reg.dout;
  assign flash_dq_oe = s_reg.oe;
  assign chip_sel_n = s_reg.cs_n;
  assign out_gate_n = s_reg.og_n;
  assign wr_strobe_n = s_reg.we_n;
  assign reset_n = s_reg.rst_n;
  assign reset_hv_en = s_reg.hv;

endmodule : flash_host_ctrl

//--- src/flash_host_pkg.sv
// Constants and types shared by the parallel flash host controller
// ****************************************************************
// ****************************************************************
package flash_host_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int unsigned clk_period_ns = 20;
  localparam int unsigned rd_wr_gap_ns = 20;
  localparam int unsigned rd_wr_gap_cyc = (rd_wr_gap_ns + clk_period_ns - 1) / clk_period_ns;
  localparam int unsigned hv_setup_us = 4;
  localparam int unsigned hv_setup_cyc = (hv_setup_us * 1000 + clk_period_ns - 1) / clk_period_ns;
  localparam int unsigned busy_delay_ns = 90;
  localparam int unsigned busy_delay_cyc = (busy_delay_ns + clk_period_ns - 1) / clk_period_ns;
  localparam int unsigned reset_ready_us = 35;
  localparam int unsigned reset_ready_cyc = (reset_ready_us * 1000) / clk_period_ns;
  localparam int unsigned pulse_ns = 35;
  localparam int unsigned pulse_cyc = (pulse_ns + clk_period_ns - 1) / clk_period_ns;
  localparam int unsigned pulse_high_ns = 20;
  localparam int unsigned pulse_high_cyc = (pulse_high_ns + clk_period_ns - 1) / clk_period_ns;

  // ****************************************************************
  // Address field positions and command words
  // ****************************************************************
  localparam int unsigned addr_bit_six = 6;
  localparam int unsigned addr_bit_one = 1;
  localparam int unsigned addr_bit_zero = 0;
  localparam int unsigned busy_toggle_bit = 6;
  localparam int unsigned polled_data_bit = 7;
  localparam int unsigned erase_suspend_toggle_bit = 2;
  localparam logic [15:0] unlock_addr_a = 16'h0555;
  localparam logic [15:0] unlock_addr_b = 16'h02aa;
  localparam logic [7:0] unlock_data_a = 8'haa;
  localparam logic [7:0] unlock_data_b = 8'h55;
  localparam logic [7:0] cmd_program = 8'ha0;
  localparam logic [7:0] cmd_erase_setup = 8'h80;
  localparam logic [7:0] cmd_sector_erase = 8'h30;

  // Operations requested by the user
  typedef enum logic [2:0] {
    op_read, op_program, op_erase, op_status, op_prot, op_unprot
  } op_t;

  // Bus sequencer states
  typedef enum logic [2:0] {
    st_idle, st_gap, st_wr_low, st_wr_high, st_rd_low, st_hv_wait, st_done
  } state_t;

endpackage : flash_host_pkg

//--- tb/flash_host_checker.sv
// Pin-level assertions for the flash host controller
module flash_host_checker
  import flash_host_pkg::*;
#(
  parameter int unsigned hv_cycles = hv_setup_cyc
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Flash pins
  input wire logic [15:0] flash_addr,
  input wire logic [7:0] flash_dq_out,
  input wire logic flash_dq_oe,
  input wire logic chip_sel_n,
  input wire logic out_gate_n,
  input wire logic wr_strobe_n,
  input wire logic reset_hv_en
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Helpers
  // ****
  int unsigned hv_cnt; // Cycles at high voltage so far
  // Counter, since a 4 us wait is too long to unroll
  always_ff @(posedge mclk or negedge rst_b)
    if (!rst_b) hv_cnt <= 0;
    else hv_cnt <= reset_hv_en ? hv_cnt + 1 : 0;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence wr_pulse; !wr_strobe_n [*2]; endsequence
  sequence wr_release; $rose(wr_strobe_n); endsequence
  // ****
  // Assertions
  // ****
  strobe_width_a: assert property ($fell(wr_strobe_n) |-> wr_pulse)
    else $error("write pulse shorter than two cycles");
  write_qual_a: assert property (!wr_strobe_n |-> out_gate_n && (chip_sel_n || flash_dq_oe))
    else $error("write without driven data or with gate low");
  cs_follow_a: assert property (!wr_strobe_n && chip_sel_n |=> !chip_sel_n)
    else $error("strobe low without select following");
  write_hold_a: assert property (wr_release |-> $stable(flash_addr) && $stable(flash_dq_out))
    else $error("address or data moved at write end");
  rd_wr_gap_a: assert property ($rose(out_gate_n) |-> wr_strobe_n [*2])
    else $error("write starts right at read end");
  read_clean_a: assert property (!out_gate_n |-> wr_strobe_n && !flash_dq_oe)
    else $error("status read overlaps a driven bus");
  hv_setup_a: assert property ($fell(wr_strobe_n) && reset_hv_en |-> hv_cnt + 1 >= hv_cycles)
    else $error("write too soon after high voltage");
endmodule : flash_host_checker

bind flash_host_ctrl flash_host_checker #(.hv_cycles(hv_cycles)) flash_host_checker_inst (
  .mclk, .rst_b, .flash_addr, .flash_dq_out, .flash_dq_oe, .chip_sel_n, .out_gate_n,
  .wr_strobe_n, .reset_hv_en);

//--- tb/flash_model.sv
// Behavioural parallel flash device answering the host pins
module flash_model #(
  parameter int prog_ns = 2000,
  parameter int erase_ns = 4000
)
(
  // Pins from the host
  input wire logic [15:0] flash_addr,
  input wire logic [7:0] flash_dq_out,
  input wire logic chip_sel_n,
  input wire logic out_gate_n,
  input wire logic wr_strobe_n,
  input wire logic reset_n,
  // Pins to the host
  output logic [7:0] flash_dq_in,
  output logic ready_busy_out_n = 1'b1
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [256] = '{default: 8'hff}; // Small array, low address byte
  logic busy = 0, erasing = 0, arm = 0, er_arm = 0, tog6 = 0, tog2 = 0;
  logic [7:0] pdat = 0, last = 0, tgt = 0;
  logic [3:0] sect = 0; // Sector is address bits 7..4
  logic [15:0] wa = 0, rd_addr = 0;
  int wr_cnt = 0, gen = 0; // gen cancels an aborted algorithm
  wire wr_n = chip_sel_n | wr_strobe_n;
  wire rd_n = chip_sel_n | out_gate_n;
  // Released bus shows the inverse of the last value, never a stale copy
  assign flash_dq_in = rd_n ? ~last : busy ? {~erasing & ~pdat[7], tog6, 3'h0, tog2, 2'h0}
    : mem[flash_addr[7:0]];
  always @(flash_dq_in) if (!rd_n) last = flash_dq_in;
  // Embedded program or erase
  task automatic run(input bit er);
    int g;
    g = gen;
    fork begin
      #60 ready_busy_out_n = 1'b0;
      if (er) foreach (mem[i]) if (i[7:4] == sect) mem[i] = 8'h00;
      #(er ? erase_ns : prog_ns);
      if (g == gen) begin
        if (er) begin
          foreach (mem[i]) if (i[7:4] == sect) mem[i] = 8'hff;
        end else mem[tgt] = mem[tgt] & pdat;
        busy = 0;
        erasing = 0;
        ready_busy_out_n = 1'b1;
      end
    end join_none
  endtask : run
  // Address at the later falling strobe
  always @(negedge wr_n) wa = flash_addr;
  // Data at the first rising strobe; commands decoded here
  always @(posedge wr_n) if (reset_n && !busy) begin
    wr_cnt++;
    if (arm) begin
      arm = 0;
      busy = 1;
      pdat = flash_dq_out;
      tgt = wa[7:0];
      run(1'b0);
    end else if (er_arm && flash_dq_out == 8'h30) begin
      er_arm = 0;
      busy = 1;
      erasing = 1;
      sect = wa[7:4];
      run(1'b1);
    end else if (flash_dq_out == 8'ha0) arm = 1;
    else if (flash_dq_out == 8'h80) er_arm = 1;
  end
  // A finished read flips toggle bit 6 while busy, and bit 2 only while erasing the sector read
  always @(negedge rd_n) rd_addr = flash_addr;
  always @(posedge rd_n) begin
    tog6 ^= busy;
    tog2 ^= erasing && rd_addr[7:4] == sect;
  end
  // Reset pin low aborts the algorithm
  always @(negedge reset_n) begin
    gen++;
    arm = 0;
    er_arm = 0;
    #500 busy = 0;
    erasing = 0;
    ready_busy_out_n = 1'b1;
  end
endmodule : flash_model

//--- tb/testbench.sv
// Self-checking bench for the flash host controller
module testbench
  import flash_host_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0, rst_b = 0, clk_en = 1, req_valid = 0, bypass_en = 0, cs_ctrl_wr = 0;
  logic hv_unprotect = 0, abort_req = 0, req_ready, rsp_valid, op_busy, toggle_seen;
  logic suspend_toggle_seen, flash_dq_oe, chip_sel_n, out_gate_n, wr_strobe_n, reset_n;
  logic reset_hv_en, ready_busy_out_n;
  logic [1:0] tsn; // Toggle flags seen after a read
  logic [2:0] req_op = 0;
  logic [15:0] req_addr = 0, flash_addr;
  logic [7:0] req_data = 0, rdat, rsp_data, flash_dq_in, flash_dq_out;
  int n_fail = 0, check_count = 0;
  always #10 mclk = ~mclk;
  flash_host_ctrl #(.hv_cycles(4), .ready_cycles(8)) flash_host_ctrl_inst (.mclk, .rst_b,
    .clk_en, .req_valid, .req_op, .req_addr, .req_data, .bypass_en, .cs_ctrl_wr,
    .hv_unprotect, .abort_req, .req_ready, .rsp_valid, .rsp_data, .op_busy, .toggle_seen,
    .suspend_toggle_seen, .flash_addr, .flash_dq_in, .flash_dq_out, .flash_dq_oe,
    .chip_sel_n, .out_gate_n, .wr_strobe_n, .reset_n, .reset_hv_en, .ready_busy_out_n);
  flash_model flash_model_inst (.flash_addr, .flash_dq_out, .chip_sel_n, .out_gate_n,
    .wr_strobe_n, .reset_n, .flash_dq_in, .ready_busy_out_n);
  // ****
  // Tasks
  // ****
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic print_verdict();
    $display("Checks %0d errors %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict
  // Request held until taken; called just after a rising edge
  task automatic req(input op_t op, input logic [15:0] a, input logic [7:0] d);
    req_valid <= 1;
    req_op <= op;
    req_addr <= a;
    req_data <= d;
    do @(negedge mclk); while (req_ready !== 1'b1);
    @(posedge mclk);
    req_valid <= 0;
  endtask : req
  task automatic rd(input op_t op, input logic [15:0] a);
    req(op, a, 8'h00);
    do @(negedge mclk); while (rsp_valid !== 1'b1);
    @(negedge mclk);
    rdat = rsp_data;
    tsn = {toggle_seen, suspend_toggle_seen};
    @(posedge mclk);
  endtask : rd
  task automatic until_busy();
    do @(negedge mclk); while (ready_busy_out_n !== 1'b0);
    @(posedge mclk);
  endtask : until_busy
  task automatic until_idle();
    do @(negedge mclk); while (op_busy !== 1'b0 || req_ready !== 1'b1);
    @(posedge mclk);
  endtask : until_idle
  task automatic prog(input logic [7:0] a, input logic [7:0] d, input logic [7:0] n);
    flash_model_inst.wr_cnt = 0;
    req(op_program, {8'h00, a}, d);
    until_busy();
    // Once our own sequencing is over, busy must come from the pin alone
    do @(negedge mclk); while (req_ready !== 1'b1);
    check({7'h0, op_busy}, 8'h01);
    @(posedge mclk);
    rd(op_status, {8'h00, a});
    check({7'h0, rdat[7]}, {7'h0, ~d[7]});
    rd(op_status, 16'h00ff);
    check({7'h0, tsn[1]}, 8'h01);
    until_idle();
    check(flash_model_inst.wr_cnt[7:0], n);
    rd(op_read, {8'h00, a});
    check(rdat, d);
  endtask : prog
  // ****
  // Main sequence
  // ****
  initial begin
    repeat (20) @(posedge mclk);
    rst_b <= 1;
    @(posedge mclk);
    prog(8'h12, 8'h5a, 8'h04);
    bypass_en <= 1;
    prog(8'h34, 8'ha5, 8'h02);
    bypass_en <= 0;
    cs_ctrl_wr <= 1;
    prog(8'h56, 8'hc3, 8'h04);
    cs_ctrl_wr <= 0;
    hv_unprotect <= 1;
    prog(8'h78, 8'h0f, 8'h04);
    hv_unprotect <= 0;
    // Erase, suspend bit only moves inside the erased sector
    flash_model_inst.wr_cnt = 0;
    req(op_erase, 16'h0010, 8'h00);
    until_busy();
    rd(op_status, 16'h0034);
    rd(op_status, 16'h0012);
    check({6'h0, tsn}, 8'h02);
    rd(op_status, 16'h0013);
    check({6'h0, tsn}, 8'h03);
    until_idle();
    check(flash_model_inst.wr_cnt[7:0], 8'h06);
    rd(op_read, 16'h0012);
    check(rdat, 8'hff);
    // Protect and unprotect address patterns
    for (int k = 0; k < 2; k++) begin
      rd(k ? op_unprot : op_prot, 16'h0000);
      check({5'h0, flash_model_inst.rd_addr[6], flash_model_inst.rd_addr[1:0]},
        {5'h0, k[0], 2'b10});
    end
    // Abort an erase; the sector keeps its zero preprogramming
    req(op_erase, 16'h0030, 8'h00);
    until_busy();
    @(posedge mclk);
    abort_req <= 1;
    @(negedge mclk);
    @(negedge mclk);
    check({7'h0, reset_n}, 8'h00);
    repeat (24) @(posedge mclk);
    abort_req <= 0;
    until_idle();
    rd(op_read, 16'h0034);
    check(rdat, 8'h00);
    print_verdict();
  end
  // Watchdog, far beyond the expected 20 us
  initial begin
    #200000;
    n_fail++;
    print_verdict();
  end
endmodule : testbench
